// >>> hw/secp_host.sv
// Host controller that runs instructions on a four-wire serial memory.
module secp_host
	import secp_pkg::*;
#(
	parameter int unsigned PROG_CYC = T_PROG_CYC
)
(
	// Clock, reset and enable.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// User command port.
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic [2:0] i_cmd_op,
	input wire logic [3:0] i_cmd_addr,
	input wire logic [15:0] i_cmd_wdata,
	// User response port.
	output logic o_rsp_valid,
	output logic o_rsp_err,
	output logic [15:0] o_rsp_rdata,
	output logic o_prog_en,
	// Serial link pins.
	output logic o_cs,
	output logic o_shift_clock,
	output logic o_serial_in,
	output logic o_serial_in_oe,
	input wire logic i_serial_out
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SELECT,
		ST_CMD,
		ST_WDATA,
		ST_RDATA,
		ST_PROG,
		ST_STOP,
		ST_GAP
	} secp_state_e;

	secp_tick_if tk();

	secp_state_e state_reg, state_next;
	secp_op_e op_reg, op_next;
	logic [8:0] cmd_reg, cmd_next;
	logic [15:0] data_reg, data_next;
	logic [15:0] rd_reg, rd_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [PROG_W-1:0] timer_reg, timer_next;
	logic cs_reg, cs_next;
	logic shclk_reg, shclk_next;
	logic si_reg, si_next;
	logic oe_reg, oe_next;
	logic en_reg, en_next;
	logic rsp_reg, rsp_next;
	logic err_reg, err_next;
	logic so_m1_reg, so_m2_reg, so_m3_reg, so_val_reg;

	////////////////////////////////////////////////////////////////////////
	// The serial output is asynchronous; three stages, change on agreement.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			so_m1_reg <= 1'b0;
			so_m2_reg <= 1'b0;
			so_m3_reg <= 1'b0;
			so_val_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			so_m1_reg <= i_serial_out;
			so_m2_reg <= so_m1_reg;
			so_m3_reg <= so_m2_reg;
			if (so_m2_reg == so_m3_reg)
			begin
				so_val_reg <= so_m3_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The divider stops during programming so the shift clock rests.
	assign tk.run = (state_reg != ST_IDLE) && (state_reg != ST_PROG);

	secp_tick_gen u_tick_gen (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.t(tk.gen)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer: next values for the whole frame state.
	always_comb
	begin
		state_next = state_reg;
		op_next = op_reg;
		cmd_next = cmd_reg;
		data_next = data_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		timer_next = timer_reg;
		cs_next = cs_reg;
		shclk_next = shclk_reg;
		si_next = si_reg;
		oe_next = oe_reg;
		en_next = en_reg;
		rsp_next = 1'b0;
		err_next = 1'b0;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (i_cmd_valid)
				begin
					op_next = secp_op_e'(i_cmd_op);
					cmd_next = secp_cmd_bits(secp_op_e'(i_cmd_op), i_cmd_addr);
					data_next = i_cmd_wdata;
					// Refused here rather than sent to the memory.
					if (secp_is_prog(secp_op_e'(i_cmd_op)) && !en_reg)
					begin
						rsp_next = 1'b1;
						err_next = 1'b1;
					end
					else
					begin
						// Select rises while serial in is held low.
						state_next = ST_SELECT;
						cs_next = 1'b1;
						si_next = 1'b0;
						oe_next = 1'b1;
					end
				end
			end
			ST_SELECT:
			begin
				if (tk.tick)
				begin
					// First bit is the start bit; low to high.
					state_next = ST_CMD;
					cnt_next = '0;
					si_next = cmd_reg[8];
				end
			end
			ST_CMD:
			begin
				if (tk.tick && !shclk_reg)
				begin
					shclk_next = 1'b1; // Device takes the bit here.
				end
				else if (tk.tick)
				begin
					shclk_next = 1'b0;
					cnt_next = cnt_reg + 5'h01;
					cmd_next = {cmd_reg[7:0], 1'b0};
					si_next = cmd_reg[7];
					if (cnt_reg == CMD_LAST)
					begin
						cnt_next = '0;
						si_next = 1'b0;
						unique case (op_reg)
							OP_READ:
							begin
								// Let go of the shared wire.
								state_next = ST_RDATA;
								oe_next = 1'b0;
							end
							OP_WRITE:
							begin
								state_next = ST_WDATA;
								si_next = data_reg[15];
							end
							OP_ERASE, OP_FILL_ALL, OP_CLEAR_ALL:
							begin
								// Select low starts programming.
								state_next = ST_PROG;
								cs_next = 1'b0;
								timer_next = '0;
							end
							default:
							begin
								// Enable and disable need no more bits.
								en_next = (op_reg == OP_PROG_EN);
								state_next = ST_GAP;
								cs_next = 1'b0;
								rsp_next = 1'b1;
							end
						endcase
					end
				end
			end
			ST_WDATA:
			begin
				if (tk.tick && !shclk_reg)
				begin
					shclk_next = 1'b1;
				end
				else if (tk.tick)
				begin
					shclk_next = 1'b0;
					cnt_next = cnt_reg + 5'h01;
					data_next = {data_reg[14:0], 1'b0};
					si_next = data_reg[14];
					if (cnt_reg == WR_LAST)
					begin
						// Exactly sixteen data bits, then program.
						state_next = ST_PROG;
						cs_next = 1'b0;
						si_next = 1'b0;
						timer_next = '0;
					end
				end
			end
			ST_RDATA:
			begin
				if (tk.tick && !shclk_reg)
				begin
					// Sample just before the rise; dummy falls off top.
					shclk_next = 1'b1;
					rd_next = {rd_reg[14:0], so_val_reg};
				end
				else if (tk.tick)
				begin
					shclk_next = 1'b0;
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == RD_LAST)
					begin
						// Seventeen clocks, then deselect and take back the output.
						state_next = ST_GAP;
						cs_next = 1'b0;
						oe_next = 1'b1;
						cnt_next = '0;
						rsp_next = 1'b1;
					end
				end
			end
			ST_PROG:
			begin
				// Fixed low time keeps well inside the limit.
				timer_next = timer_reg + PROG_W'(1);
				if (timer_reg == PROG_W'(PROG_CYC - 1))
				begin
					// Select rises with no start bit: divider runs again for one half period.
					state_next = ST_STOP;
					cs_next = 1'b1;
				end
			end
			ST_STOP:
			begin
				if (tk.tick)
				begin
					state_next = ST_GAP;
					cs_next = 1'b0;
					cnt_next = '0;
					rsp_next = 1'b1;
				end
			end
			ST_GAP:
			begin
				// Two half periods low: one full clock before reuse.
				if (tk.tick)
				begin
					cnt_next = cnt_reg + 5'h01;
					if (cnt_reg == GAP_LAST)
					begin
						state_next = ST_IDLE;
						cnt_next = '0;
					end
				end
			end
		endcase
	end

	// Registers only; reset leaves programming disabled.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state_reg <= ST_IDLE;
			op_reg <= OP_READ;
			cmd_reg <= '0;
			data_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			timer_reg <= '0;
			cs_reg <= 1'b0;
			shclk_reg <= 1'b0;
			si_reg <= 1'b0;
			oe_reg <= 1'b1;
			en_reg <= 1'b0;
			rsp_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			state_reg <= state_next;
			op_reg <= op_next;
			cmd_reg <= cmd_next;
			data_reg <= data_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			timer_reg <= timer_next;
			cs_reg <= cs_next;
			shclk_reg <= shclk_next;
			si_reg <= si_next;
			oe_reg <= oe_next;
			en_reg <= en_next;
			rsp_reg <= rsp_next;
			err_reg <= err_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs. Ready is combinational; everything else is a flip-flop.
	assign o_cmd_ready = (state_reg == ST_IDLE);
	assign o_rsp_valid = rsp_reg;
	assign o_rsp_err = err_reg;
	assign o_rsp_rdata = rd_reg;
	assign o_prog_en = en_reg;
	assign o_cs = cs_reg;
	assign o_shift_clock = shclk_reg;
	assign o_serial_in = si_reg;
	assign o_serial_in_oe = oe_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks. Count of select-low cycles for the spacing check.
	logic [7:0] low_cnt_reg;

	always_ff @(posedge i_clk)
	begin
		// Reset counts as a long idle, so the first frame is not flagged.
		if (i_sys_rst)
		begin
			low_cnt_reg <= 8'hFF;
		end
		else if (cs_reg)
		begin
			low_cnt_reg <= '0;
		end
		else if (i_ce && low_cnt_reg != 8'hFF)
		begin
			low_cnt_reg <= low_cnt_reg + 8'h01;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst || !i_ce);

	chk_start_low: assert property ($rose(o_cs) |-> !o_serial_in)
		else $error("Serial in high when select rose.");
	chk_bit_stable: assert property (
		$rose(o_shift_clock) |-> $stable(o_serial_in))
		else $error("Serial in moved on a shift clock rise.");
	chk_clock_high: assert property (
		$rose(o_shift_clock) |-> o_shift_clock [*8])
		else $error("Shift clock high phase too short.");
	chk_prog_bound: assert property (
		state_reg == ST_PROG |-> timer_reg < PROG_W'(T_PROG_MAX_CYC))
		else $error("Programming low time runs past its limit.");
	chk_prog_low: assert property (
		$rose(state_reg == ST_PROG) |-> !o_cs [*8])
		else $error("Select not held low while programming.");
	chk_enable_gate: assert property (
		(state_reg == ST_SELECT) && secp_is_prog(op_reg) |-> en_reg)
		else $error("Programming sent while disabled.");
	chk_gap_len: assert property (
		$rose(o_cs) |-> $past(low_cnt_reg) >= 8'(2 * LINK_HALF_CYC))
		else $error("Select low gap shorter than one shift clock.");
	chk_wire_release: assert property ((state_reg == ST_RDATA) |->
		!o_serial_in_oe)
		else $error("Host drives the wire during read out.");

	cov_read_done: cover property ((state_reg == ST_RDATA) ##1
		(state_reg == ST_GAP));
	cov_write_prog: cover property ((state_reg == ST_WDATA) ##1
		(state_reg == ST_PROG));
	cov_refused: cover property (o_rsp_valid && o_rsp_err);

endmodule

// >>> hw/secp_pkg.sv
// Shared constants, types and helpers for the serial memory host controller.
package secp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing. Times keep their printed unit; cycle counts derive from them.
	localparam int unsigned CLK_PERIOD_NS = 100;
	// Shortest high phase of the shift clock.
	localparam int unsigned LINK_HIGH_NS = 2000;
	localparam int unsigned LINK_HALF_CYC =
		(LINK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Select low time that performs a programming operation.
	localparam int unsigned T_PROG_US = 10000;
	localparam int unsigned T_PROG_CYC =
		(T_PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Upper limit for the programming interval.
	localparam int unsigned T_PROG_MAX_US = 30000;
	localparam int unsigned T_PROG_MAX_CYC =
		(T_PROG_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned HALF_W = 5;
	localparam int unsigned PROG_W = 19;

	////////////////////////////////////////////////////////////////////////
	// Frame sizes, given as the last index of each bit counter.
	localparam logic [4:0] CMD_LAST = 5'h08;
	localparam logic [4:0] WR_LAST = 5'h0F;
	localparam logic [4:0] RD_LAST = 5'h10;
	localparam logic [4:0] GAP_LAST = 5'h01;

	////////////////////////////////////////////////////////////////////////
	// Serial patterns, start bit included, most significant bit sent first.
	localparam logic [4:0] PAT_READ = 5'h10;
	localparam logic [4:0] PAT_WRITE = 5'h18;
	localparam logic [4:0] PAT_ERASE = 5'h14;
	localparam logic [8:0] PAT_PROG_EN = 9'h1C1;
	localparam logic [8:0] PAT_PROG_DIS = 9'h1C2;
	localparam logic [8:0] PAT_FILL_ALL = 9'h1C4;
	localparam logic [8:0] PAT_CLEAR_ALL = 9'h1C5;

	// Operations the user port can request.
	typedef enum logic [2:0] {
		OP_READ,
		OP_WRITE,
		OP_ERASE,
		OP_PROG_EN,
		OP_PROG_DIS,
		OP_FILL_ALL,
		OP_CLEAR_ALL
	} secp_op_e;

	// Operations that change stored contents.
	function automatic logic secp_is_prog(input secp_op_e op);
		return (op == OP_WRITE) || (op == OP_ERASE) ||
			(op == OP_FILL_ALL) || (op == OP_CLEAR_ALL);
	endfunction

	// Serial pattern for an operation and register address.
	function automatic logic [8:0] secp_cmd_bits(input secp_op_e op,
		input logic [3:0] addr);
		logic [8:0] bits;
		bits = PAT_PROG_DIS;
		unique case (op)
			OP_READ: bits = {PAT_READ, addr};
			OP_WRITE: bits = {PAT_WRITE, addr};
			OP_ERASE: bits = {PAT_ERASE, addr};
			OP_PROG_EN: bits = PAT_PROG_EN;
			OP_PROG_DIS: bits = PAT_PROG_DIS;
			OP_FILL_ALL: bits = PAT_FILL_ALL;
			OP_CLEAR_ALL: bits = PAT_CLEAR_ALL;
			default: bits = PAT_PROG_DIS;
		endcase
		return bits;
	endfunction

endpackage

// >>> hw/secp_tick_if.sv
// Run request and half-period tick between the controller and its divider.
interface secp_tick_if;
	logic run;
	logic tick;
	modport gen(input run, output tick);
	modport user(output run, input tick);
endinterface

// >>> hw/secp_sk_gen.sv
// Half-period timer that paces the shift clock made by the controller.
module secp_tick_gen
	import secp_pkg::*;
(
	// Clock, reset and enable.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Pacing link to the controller.
	secp_tick_if.gen t
);

	localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(LINK_HALF_CYC - 1);

	logic [HALF_W-1:0] cnt_reg;
	logic [HALF_W-1:0] cnt_next;

	////////////////////////////////////////////////////////////////////////
	// A tick comes every half period; the count restarts whenever run drops.
	assign t.tick = t.run && (cnt_reg == HALF_LAST);

	always_comb
	begin
		cnt_next = cnt_reg;
		if (!t.run || t.tick)
		begin
			cnt_next = '0;
		end
		else
		begin
			cnt_next = cnt_reg + HALF_W'(1);
		end
	end

	// Registers only; clock enable freezes the count.
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			cnt_reg <= '0;
		end
		else if (i_ce)
		begin
			cnt_reg <= cnt_next;
		end
	end

endmodule

// >>> testbench/secp_mem_model.sv
// Behavioural serial memory on the far side of the host controller.
module secp_mem_model
	import secp_pkg::*;
#(
	parameter real PROG_MIN_NS = 10000000.0
)
(
	// Link pins, memory side.
	input wire logic i_cs,
	input wire logic i_shift_clock,
	input wire logic i_serial_in,
	output logic o_do,
	// Protocol faults counted so far.
	output int o_faults
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [16];
	logic [15:0] sh;
	logic [7:0] cmd;
	logic [3:0] adr;
	logic en = 1'b0;
	logic drv = 1'b0;
	logic q = 1'b0;
	logic pend = 1'b0;
	logic rd = 1'b0;
	secp_op_e kind = OP_READ;
	int st = 0;
	int n = 0;
	realtime t_rise = -1.0e9;
	realtime t_low = -1.0e9;
	initial o_faults = 0;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;

	// A released pin shows the inverse of its last bit, so stale data fails.
	assign o_do = drv ? q : ~q;

	// Decode the eight bits after the start bit.
	task automatic decode();
		adr = cmd[3:0];
		st = 4;
		n = 0;
		casez (cmd)
			8'b0000????:
			begin
				sh = mem[adr];
				q = 1'b0;
				drv = 1'b1;
				st = 2;
			end
			8'b1000????:
			begin
				kind = OP_WRITE;
				st = 3;
			end
			8'b0100????:
			begin
				kind = OP_ERASE;
				pend = en;
			end
			8'hC1: en = 1'b1;
			8'hC2: en = 1'b0;
			8'hC4, 8'hC5:
			begin
				kind = cmd[0] ? OP_CLEAR_ALL : OP_FILL_ALL;
				pend = en;
			end
			default: o_faults++;
		endcase
	endtask

	////////////////////////////////////////////////////////////////////
	// Select rise ends the frame and commits a pending program pulse.
	always @(posedge i_cs)
	begin
		if (rd && $realtime - t_low < 4000.0)
			o_faults++;
		if (pend)
		begin
			if ($realtime - t_low > 30.0e6 || $realtime - t_low < PROG_MIN_NS)
				o_faults++;
			case (kind)
				OP_WRITE: mem[adr] = sh;
				OP_ERASE: mem[adr] = 16'hFFFF;
				OP_FILL_ALL: foreach (mem[i]) mem[i] = 16'h0000;
				default: foreach (mem[i]) mem[i] = 16'hFFFF;
			endcase
		end
		pend = 1'b0;
		rd = 1'b0;
		st = 0;
		n = 0;
	end

	// Deselect releases the output and starts the program pulse.
	always @(negedge i_cs)
	begin
		t_low = $realtime;
		drv = 1'b0;
	end

	// A short high phase means the clock ran too fast.
	always @(negedge i_shift_clock)
		if ($realtime - t_rise < 2000.0)
			o_faults++;

	// Every bit moves on the shift clock's rising edge.
	always @(posedge i_shift_clock)
	begin
		if ($realtime - t_rise < 4000.0)
			o_faults++;
		t_rise = $realtime;
		if (i_cs)
			case (st)
				0: st = (i_serial_in === 1'b1) ? 1 : 0;
				1:
				begin
					cmd = {cmd[6:0], i_serial_in};
					n++;
					if (n == 8)
						decode();
				end
				2:
				begin
					q = sh[15];
					sh = {sh[14:0], 1'b0};
					n++;
					rd = (n == 16);
					st = rd ? 5 : 2;
				end
				3:
				begin
					sh = {sh[14:0], i_serial_in};
					n++;
					pend = (n == 16) && en;
					st = (n == 16) ? 4 : 3;
				end
				5: q = i_serial_in;
				default: ;
			endcase
	end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the serial memory host controller.
module tb
	import secp_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 50;
	// One expected response.
	typedef struct {
		logic err;
		logic rd;
		logic [15:0] data;
		int take;
		int lat;
	} secp_note_s;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_ce = 1'b1;
	logic i_cmd_valid = 1'b0;
	logic [2:0] i_cmd_op = 3'h0;
	logic [3:0] i_cmd_addr = 4'h0;
	logic [15:0] i_cmd_wdata = 16'h0000;
	logic o_cmd_ready, o_rsp_valid, o_rsp_err, o_prog_en, o_cs;
	logic o_shift_clock, o_serial_in, o_serial_in_oe, mem_do, wire_lvl;
	logic [15:0] o_rsp_rdata;
	int mem_faults;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic jit = 1'b0;
	logic [31:0] rs = 32'h00003D11;
	logic [15:0] d;
	logic [3:0] a;
	secp_note_s exp_q [$];
	secp_op_e pg [4] = '{OP_WRITE, OP_ERASE, OP_FILL_ALL, OP_CLEAR_ALL};

	// Shared data wire: the party with its enable up sets the level.
	assign wire_lvl = o_serial_in_oe ? o_serial_in : mem_do;

	secp_host #(.PROG_CYC(P)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_ce(i_ce), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
		.i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
		.i_cmd_wdata(i_cmd_wdata), .o_rsp_valid(o_rsp_valid),
		.o_rsp_err(o_rsp_err), .o_rsp_rdata(o_rsp_rdata),
		.o_prog_en(o_prog_en), .o_cs(o_cs), .o_shift_clock(o_shift_clock),
		.o_serial_in(o_serial_in), .o_serial_in_oe(o_serial_in_oe),
		.i_serial_out(wire_lvl));
	secp_mem_model #(.PROG_MIN_NS(P * 100.0)) mem (.i_cs(o_cs),
		.i_shift_clock(o_shift_clock), .i_serial_in(wire_lvl), .o_do(mem_do),
		.o_faults(mem_faults));

	////////////////////////////////////////////////////////////////////
	// System clock.
	initial forever #50 i_clk = ~i_clk;

	// Clock enable drops one cycle in three while gaps are wanted.
	always @(posedge i_clk)
	begin
		#1;
		i_ce = !jit || (cyc % 3 != 0);
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	// Bounded wait for idle; an empty queue is required when asked.
	task automatic wait_idle(input logic need_empty);
		int k;
		k = 0;
		while ((o_cmd_ready !== 1'b1 || (need_empty && exp_q.size() != 0))
			&& k < 5000)
		begin
			@(posedge i_clk);
			#1;
			k++;
		end
		if (k == 5000)
		begin
			fails++;
			report_and_stop();
		end
	endtask

	// Present one request until taken and note the answer it should get.
	task automatic op(input secp_op_e o, input logic [3:0] ad,
		input logic [15:0] wd, input logic er, input logic r,
		input logic [15:0] ex, input int lat);
		secp_note_s nt;
		// Let an edge pass so valid never drops and rises in one step.
		@(posedge i_clk);
		#1;
		wait_idle(1'b0);
		i_cmd_valid = 1'b1;
		i_cmd_op = o;
		i_cmd_addr = ad;
		i_cmd_wdata = wd;
		do @(posedge i_clk); while (i_ce !== 1'b1);
		#1;
		nt = '{er, r, ex, cyc, lat};
		exp_q.push_back(nt);
		i_cmd_valid = 1'b0;
	endtask

	task automatic done(input string s);
		wait_idle(1'b1);
		$display("test %s finished", s);
	endtask

	// Each response is matched against the oldest note.
	always @(posedge i_clk)
	begin
		secp_note_s nt;
		cyc++;
		// A frozen edge holds the pulse; only enabled edges consume it.
		if (o_rsp_valid === 1'b1 && i_ce === 1'b1 && exp_q.size() == 0)
			chk("spare response", 16'h0000, 16'h0001);
		else if (o_rsp_valid === 1'b1 && i_ce === 1'b1)
		begin
			nt = exp_q.pop_front();
			chk("error flag", {15'h0000, nt.err}, {15'h0000, o_rsp_err});
			if (nt.rd)
				chk("read data", nt.data, o_rsp_rdata);
			if (nt.lat > 0)
				chk("latency", 16'(nt.lat), 16'(cyc - nt.take));
		end
	end

	initial
	begin
		repeat (5) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		chk("enable flag", 16'h0000, {15'h0000, o_prog_en});
		foreach (pg[i]) op(pg[i], 4'h3, 16'h1234, 1'b1, 1'b0, 16'h0, 1);
		done("refused while disabled");
		op(OP_PROG_EN, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0, 381);
		done("program enable");
		chk("enable flag", 16'h0001, {15'h0000, o_prog_en});
		for (int i = 0; i < 4; i++)
		begin
			a = (i < 2) ? 4'(i * 15) : 4'(rnd());
			d = 16'(rnd());
			op(OP_WRITE, a, d, 1'b0, 1'b0, 16'h0, 1041 + P);
			op(OP_READ, a, 16'h0, 1'b0, 1'b1, d, 1061);
		end
		op(OP_ERASE, a, 16'h0, 1'b0, 1'b0, 16'h0, 401 + P);
		op(OP_READ, a, 16'h0, 1'b0, 1'b1, 16'hFFFF, 1061);
		done("write, read and erase");
		op(OP_FILL_ALL, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0, 401 + P);
		op(OP_CLEAR_ALL, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0, 401 + P);
		op(OP_READ, 4'(rnd()), 16'h0, 1'b0, 1'b1, 16'hFFFF, 1061);
		d = 16'(rnd());
		op(OP_WRITE, 4'h5, d, 1'b0, 1'b0, 16'h0, 1041 + P);
		done("fill and clear all");
		jit = 1'b1;
		for (int i = 0; i < 3; i++) op(OP_READ, 4'h5, 16'h0, 1'b0, 1'b1, d, 0);
		done("reads with enable gaps");
		jit = 1'b0;
		op(OP_PROG_DIS, 4'h0, 16'h0, 1'b0, 1'b0, 16'h0, 381);
		op(OP_WRITE, 4'h5, ~d, 1'b1, 1'b0, 16'h0, 1);
		op(OP_READ, 4'h5, 16'h0, 1'b0, 1'b1, d, 1061);
		done("program disable");
		op(OP_READ, 4'h5, 16'h0, 1'b0, 1'b1, d, 1061);
		repeat (510) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b1;
		exp_q.delete();
		repeat (5) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		chk("idle after reset", 16'h0001, {15'h0, o_cmd_ready & ~o_cs});
		op(OP_READ, 4'h5, 16'h0, 1'b0, 1'b1, d, 1061);
		done("reset during read");
		chk("link faults", 16'h0000, 16'(mem_faults));
		report_and_stop();
	end
endmodule
